//--- pkg/aes_pkg.sv
// Purpose: constants, types and the state carrier of the add, and and bit-skip execution unit.
// Assumes: one clock, synchronous active-high reset, AXI4-Lite register access.
// Notes: one instruction period is two clocks: take, then execute and retire.
package aes_pkg;

	localparam int DATA_W       = 8;    // accumulator and file width
	localparam int FADDR_W      = 7;    // file address width
	localparam int FILE_DEPTH   = 128;  // file registers
	localparam int BIDX_W       = 3;    // bit index width

	// register byte addresses on the AXI4-Lite port
	localparam logic [3:0] ACC_OFS   = 4'h0; // accumulator, read/write
	localparam logic [3:0] FLAG_OFS  = 4'h4; // arithmetic flags, read/write
	localparam logic [3:0] CTRL_OFS  = 4'h8; // enable, read/write
	localparam logic [3:0] COUNT_OFS = 4'hc; // retired count, read only

	// flag field positions
	localparam int FLAG_C_BIT  = 0;
	localparam int FLAG_NIB_BIT = 1; // nibble carry
	localparam int FLAG_Z_BIT  = 2;
	localparam int CTRL_EN_BIT = 0;

	// reset values
	localparam logic [7:0] ACC_RST  = 8'h00;
	localparam logic       EN_RST   = 1'b1;

	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// opcodes from the decoder; anything else executes as a no-operation
	typedef enum logic [3:0] {
		add_literal_op, add_file_op, and_literal_op, and_file_op,
		bit_clear_op, bit_set_op, skip_if_bit_set_op, skip_if_bit_low_op, nop_op
	} aes_op_e;

	// one request from the decoder
	typedef struct packed {
		aes_op_e              op;
		logic [DATA_W-1:0]    lit;   // immediate operand
		logic [FADDR_W-1:0]   faddr; // file address
		logic [BIDX_W-1:0]    bidx;  // bit index
		logic                 dest;  // 0 accumulator, 1 file register
	} aes_req_s;

	// retire report, valid for one clock
	typedef struct packed {
		logic done;       // an instruction period ended
		logic discarded;  // that period ran a no-operation for a skipped instruction
		logic skip_taken; // a bit test asked for the next instruction to be dropped
	} aes_ret_s;

	typedef enum logic [0:0] {st_take, st_exec} aes_st_e;

	// whole state of the execution unit
	typedef struct packed {
		aes_st_e            st;
		aes_req_s           req;
		logic               skip_pend;  // next accepted instruction is dropped
		logic [DATA_W-1:0]  acc;
		logic               fc, fdc, fz;
		logic               en;
		logic [31:0]        count;
		logic               ready;
		aes_ret_s           ret;
		logic               aw_held, w_held;
		logic [3:0]         aw_addr;
		logic [31:0]        wdata;
		logic [3:0]         wstrb;
		logic               awready, wready, arready;
		logic               bvalid, rvalid;
		logic [1:0]         bresp, rresp;
		logic [31:0]        rdata;
	} aes_core_s;

	// one-hot mask for a bit index, shared by set, clear and test
	function automatic logic [DATA_W-1:0] bit_mask(input logic [BIDX_W-1:0] idx);
		bit_mask = 8'h01 << idx;
	endfunction

endpackage

//--- verilog/aes_file_mem.sv
// Purpose: file register space, 128 bytes, one port, registered read.
// Assumes: a read in the clock of a write to the same address returns the byte held before the write.
// Notes: contents clear on reset so that a bench sees known values.
`timescale 1ns/1ps
module aes_file_mem import aes_pkg::*; (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic [FADDR_W-1:0] addr,
	input  wire logic               we,
	input  wire logic [DATA_W-1:0]  wdata,
	output      logic [DATA_W-1:0]  rdata
);
	// all memory state in one carrier
	typedef struct packed {
		logic [FILE_DEPTH-1:0][DATA_W-1:0] cells;
		logic [DATA_W-1:0]                 rdata;
	} aes_mem_s;

	aes_mem_s mem_r;  // registered state
	aes_mem_s mem_nxt; // next state

	// read every clock; write only when asked
	always_comb begin
		mem_nxt       = mem_r;
		mem_nxt.rdata = mem_r.cells[addr];
		if (we) begin
			mem_nxt.cells[addr] = wdata;
		end
	end

	// register the carrier
	always_ff @(posedge clk) begin
		if (rst) begin
			mem_r <= '0;
		end else begin
			mem_r <= mem_nxt;
		end
	end

	assign rdata = mem_r.rdata;
endmodule

//--- verilog/aes_exec_unit.sv
// Purpose: add, and, bit set/clear and bit-test-skip execution with AXI4-Lite register access.
// Assumes: decoder holds OP_REQ steady while OP_VALID waits for OP_READY.
// Notes: one instruction period is two clocks; a taken skip drops the next accepted request.
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module aes_exec_unit import aes_pkg::*; #(
	parameter int ADDR_W = 4 // AXI address width, bits 3:2 decoded
) (
	input  wire logic              CLK,
	input  wire logic              RST,
	input  wire logic              OP_VALID,
	input  wire aes_req_s          OP_REQ,
	output      logic              OP_READY,
	output      aes_ret_s          OP_RET,
	output      logic [DATA_W-1:0] ACC,
	input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input  wire logic              S_AXI_AWVALID,
	output      logic              S_AXI_AWREADY,
	input  wire logic [31:0]       S_AXI_WDATA,
	input  wire logic [3:0]        S_AXI_WSTRB,
	input  wire logic              S_AXI_WVALID,
	output      logic              S_AXI_WREADY,
	output      logic [1:0]        S_AXI_BRESP,
	output      logic              S_AXI_BVALID,
	input  wire logic              S_AXI_BREADY,
	input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input  wire logic              S_AXI_ARVALID,
	output      logic              S_AXI_ARREADY,
	output      logic [31:0]       S_AXI_RDATA,
	output      logic [1:0]        S_AXI_RRESP,
	output      logic              S_AXI_RVALID,
	input  wire logic              S_AXI_RREADY
);
	// refuse an address bus too narrow for the map
	if (ADDR_W < 4) begin : g_chk
		$error("ADDR_W must be at least 4");
	end

	aes_core_s           s_r;      // registered state
	aes_core_s           s_nxt;    // next state
	logic [FADDR_W-1:0]  mem_addr; // file port address
	logic                mem_we;   // file port write
	logic [DATA_W-1:0]   mem_wd;   // file port write data
	logic [DATA_W-1:0]   mem_rd;   // file data of the request under execution

	aes_file_mem u_mem (
		.clk   (CLK),
		.rst   (RST),
		.addr  (mem_addr),
		.we    (mem_we),
		.wdata (mem_wd),
		.rdata (mem_rd)
	);

	// next-state logic: bus, then execution so that execution wins over a software write
	always_comb begin
		logic [DATA_W-1:0] opnd;
		logic [DATA_W:0]   sum9;
		logic [4:0]        hsum;
		logic [DATA_W-1:0] res;
		logic              tbit;
		logic [3:0]        wa;
		opnd     = '0;
		sum9     = '0;
		hsum     = '0;
		res      = '0;
		tbit     = 1'b0;
		wa       = '0;
		s_nxt    = s_r;
		mem_addr = s_r.req.faddr;
		mem_we   = 1'b0;
		mem_wd   = '0;
		s_nxt.ret = '0;

		// write address and write data are taken in either order
		if (S_AXI_AWVALID && s_r.awready) begin
			s_nxt.aw_held = 1'b1;
			s_nxt.aw_addr = S_AXI_AWADDR[3:0];
		end
		if (S_AXI_WVALID && s_r.wready) begin
			s_nxt.w_held = 1'b1;
			s_nxt.wdata  = S_AXI_WDATA;
			s_nxt.wstrb  = S_AXI_WSTRB;
		end
		if (S_AXI_BVALID && S_AXI_BREADY) begin
			s_nxt.bvalid = 1'b0;
		end
		// both halves held and no answer pending: perform the write
		if (s_r.aw_held && s_r.w_held && !s_r.bvalid) begin
			s_nxt.aw_held = 1'b0;
			s_nxt.w_held  = 1'b0;
			s_nxt.bvalid  = 1'b1;
			s_nxt.bresp   = RESP_OKAY;
			wa            = {s_r.aw_addr[3:2], 2'h0};
			if (wa == ACC_OFS) begin
				if (s_r.wstrb[0]) s_nxt.acc = s_r.wdata[7:0];
			end else if (wa == FLAG_OFS) begin
				if (s_r.wstrb[0]) begin
					s_nxt.fc  = s_r.wdata[FLAG_C_BIT];
					s_nxt.fdc = s_r.wdata[FLAG_NIB_BIT];
					s_nxt.fz  = s_r.wdata[FLAG_Z_BIT];
				end
			end else if (wa == CTRL_OFS) begin
				if (s_r.wstrb[0]) s_nxt.en = s_r.wdata[CTRL_EN_BIT];
			end else if (wa != COUNT_OFS) begin
				// unmapped: nothing stored, error answer
				s_nxt.bresp = RESP_SLVERR;
			end
		end
		s_nxt.awready = !s_nxt.aw_held;
		s_nxt.wready  = !s_nxt.w_held;

		// read: one at a time, data registered
		if (S_AXI_RVALID && S_AXI_RREADY) begin
			s_nxt.rvalid = 1'b0;
		end
		if (S_AXI_ARVALID && s_r.arready) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp  = RESP_OKAY;
			wa           = {S_AXI_ARADDR[3:2], 2'h0};
			case (wa)
				ACC_OFS:   s_nxt.rdata = {24'h000000, s_r.acc};
				FLAG_OFS:  s_nxt.rdata = {29'h0, s_r.fz, s_r.fdc, s_r.fc};
				CTRL_OFS:  s_nxt.rdata = {31'h0, s_r.en};
				COUNT_OFS: s_nxt.rdata = s_r.count;
				default: begin
					s_nxt.rdata = 32'h00000000;
					s_nxt.rresp = RESP_SLVERR;
				end
			endcase
		end
		s_nxt.arready = !s_nxt.rvalid;

		// execution sequence
		case (s_r.st)
			st_take: begin
				// the file read starts with the take so data is ready in st_exec
				mem_addr = OP_REQ.faddr;
				if (OP_VALID && s_r.ready) begin
					s_nxt.req = OP_REQ;
					if (s_r.skip_pend) s_nxt.req.op = nop_op;
					s_nxt.st  = st_exec;
				end
			end
			st_exec: begin
				opnd = (s_r.req.op == add_file_op || s_r.req.op == and_file_op) ?
				       mem_rd : s_r.req.lit;
				// carry out of bit 7 and bit 3
				sum9 = {1'b0, s_r.acc} + {1'b0, opnd};
				hsum = {1'b0, s_r.acc[3:0]} + {1'b0, opnd[3:0]};
				tbit = |(mem_rd & bit_mask(s_r.req.bidx));
				s_nxt.skip_pend = 1'b0;
				case (s_r.req.op)
					add_literal_op, add_file_op: begin
						res       = sum9[7:0];
						s_nxt.fc  = sum9[8];
						s_nxt.fdc = hsum[4];
						s_nxt.fz  = (res == 8'h00);
					end
					and_literal_op, and_file_op: begin
						res      = s_r.acc & opnd;
						s_nxt.fz = (res == 8'h00);
					end
					default: res = s_r.acc;
				endcase
				case (s_r.req.op)
					add_literal_op, and_literal_op: s_nxt.acc = res;
					add_file_op, and_file_op: begin
						if (s_r.req.dest) begin
							mem_we = 1'b1;
							mem_wd = res;
						end else begin
							s_nxt.acc = res;
						end
					end
					bit_clear_op: begin
						mem_we = 1'b1;
						mem_wd = mem_rd & ~bit_mask(s_r.req.bidx);
					end
					bit_set_op: begin
						mem_we = 1'b1;
						mem_wd = mem_rd | bit_mask(s_r.req.bidx);
					end
					// skip when tested bit is one
					skip_if_bit_set_op: s_nxt.skip_pend = tbit;
					// skip when tested bit is zero
					skip_if_bit_low_op: s_nxt.skip_pend = !tbit;
					default: ;
				endcase
				s_nxt.ret.done       = 1'b1;
				s_nxt.ret.discarded  = s_r.skip_pend;
				s_nxt.ret.skip_taken = s_nxt.skip_pend;
				s_nxt.count          = s_r.count + 32'h00000001;
				s_nxt.st             = st_take;
			end
			default: s_nxt.st = st_take;
		endcase
		// ready is registered, so it looks at the state being entered
		s_nxt.ready = (s_nxt.st == st_take) && s_nxt.en;
	end

	// register the carrier
	always_ff @(posedge CLK) begin
		if (RST) begin
			s_r       <= '0;
			s_r.st    <= st_take;
			s_r.req   <= '{op: nop_op, default: '0};
			s_r.acc   <= ACC_RST;
			s_r.en    <= EN_RST;
			s_r.ready <= EN_RST;
			s_r.awready <= 1'b1;
			s_r.wready  <= 1'b1;
			s_r.arready <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign OP_READY      = s_r.ready;
	assign OP_RET        = s_r.ret;
	assign ACC           = s_r.acc;
	assign S_AXI_AWREADY = s_r.awready;
	assign S_AXI_WREADY  = s_r.wready;
	assign S_AXI_BVALID  = s_r.bvalid;
	assign S_AXI_BRESP   = s_r.bresp;
	assign S_AXI_ARREADY = s_r.arready;
	assign S_AXI_RVALID  = s_r.rvalid;
	assign S_AXI_RDATA   = s_r.rdata;
	assign S_AXI_RRESP   = s_r.rresp;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	logic [8:0] sum9_chk; // independent sum for flag checking
	logic       hc_chk;   // independent nibble carry
	assign sum9_chk = {1'b0, s_r.acc} + {1'b0, mem_rd};
	assign hc_chk   = 5'({1'b0, s_r.acc[3:0]} + {1'b0, mem_rd[3:0]}) > 5'h0f;

	logic exe; // a real instruction is executing
	assign exe = (s_r.st == st_exec) && !s_r.skip_pend;

	add_lit_sum_a: assert property (exe && s_r.req.op == add_literal_op |=>
		s_r.acc == 8'($past(s_r.acc) + $past(s_r.req.lit)) && s_r.ret.done)
		else $error("literal add result wrong");
	add_file_dst_a: assert property (exe && s_r.req.op == add_file_op && s_r.req.dest |->
		mem_we && mem_wd == 8'(s_r.acc + mem_rd) ##1 s_r.acc == $past(s_r.acc))
		else $error("file add destination wrong");
	and_lit_flag_a: assert property (exe && s_r.req.op == and_literal_op |=>
		s_r.acc == ($past(s_r.acc) & $past(s_r.req.lit)) && $stable(s_r.fc) &&
		s_r.fz == (s_r.acc == 8'h00))
		else $error("literal and wrong");
	and_file_dst_a: assert property (exe && s_r.req.op == and_file_op && !s_r.req.dest |->
		!mem_we ##1 s_r.acc == ($past(s_r.acc) & $past(mem_rd)) && $stable(s_r.fdc))
		else $error("file and wrong");
	bit_clr_write_a: assert property (exe && s_r.req.op == bit_clear_op |->
		mem_we && !mem_wd[s_r.req.bidx] ##1 $stable({s_r.fc, s_r.fdc, s_r.fz}))
		else $error("bit clear wrong");
	bit_set_write_a: assert property (exe && s_r.req.op == bit_set_op |->
		mem_we && mem_wd[s_r.req.bidx] && (mem_wd | bit_mask(s_r.req.bidx)) ==
		(mem_rd | bit_mask(s_r.req.bidx)))
		else $error("bit set wrong");
	skip_set_take_a: assert property (exe && s_r.req.op == skip_if_bit_set_op &&
		mem_rd[s_r.req.bidx] |=> s_r.ret.skip_taken ##[1:300] s_r.ret.done && s_r.ret.discarded)
		else $error("set skip not taken");
	skip_low_take_a: assert property (exe && s_r.req.op == skip_if_bit_low_op |=>
		s_r.ret.skip_taken == !$past(mem_rd[s_r.req.bidx]) && $stable(s_r.fz))
		else $error("low skip wrong");
	add_flags_a: assert property (exe && s_r.req.op == add_file_op |=>
		s_r.fc == $past(sum9_chk[8]) && s_r.fdc == $past(hc_chk) &&
		s_r.fz == ($past(sum9_chk[7:0]) == 8'h00))
		else $error("add flags wrong");
	period_len_a: assert property (OP_VALID && OP_READY |=>
		!OP_READY ##1 s_r.ret.done)
		else $error("instruction period not two clocks");
endmodule

//--- verif/aes_dec_model.sv
// Purpose: decoder-side partner that offers one request at a time to the execution unit.
// Assumes: called just after a rising edge; all unit outputs come from registers.
// Notes: a gap argument makes the decoder slow, so the unit sees idle periods too.
`timescale 1ns/1ps
module aes_dec_model import aes_pkg::*; (
	input  wire logic     clk,
	input  wire logic     op_ready,
	input  wire aes_ret_s op_ret,
	output      logic     op_valid,
	output      aes_req_s op_req
);
	// idle decoder drives a known but meaningless request
	initial begin
		op_valid = 1'b0;
		op_req = '0;
	end

	// offer, hold until taken, then wait for the retire pulse
	task automatic issue(input aes_req_s r, input int gap, output aes_ret_s ret, output logic ok);
		int i;
		logic taken;
		taken = 1'b0;
		ok = 1'b0;
		ret = '0;
		repeat (gap) @(posedge clk);
		op_valid <= 1'b1;
		op_req <= r;
		// ready is sampled at the edge; outputs only move in the update region
		for (i = 0; i < 40 && !taken; i++) begin
			@(posedge clk);
			taken = op_ready;
		end
		op_valid <= 1'b0;
		// released payload shows the inverse so a stale read cannot pass
		op_req <= aes_req_s'(~r);
		for (i = 0; i < 8 && taken && !ok; i++) begin
			@(posedge clk);
			#1;
			if (op_ret.done === 1'b1) begin
				ok = 1'b1;
				ret = op_ret;
			end
		end
	endtask
endmodule

//--- verif/tb.sv
// Purpose: self-checking bench for the add, and, bit and skip execution unit.
// Assumes: file contents are seen only through an and-file into the accumulator.
// Notes: the bus master waits on the slave's answers under bounded loops only.
`timescale 1ns/1ps
module tb import aes_pkg::*; ;
	logic              CLK = 1'b0;  // 125 MHz
	logic              RST = 1'b1;  // synchronous, active high
	logic              op_valid;
	aes_req_s          op_req;
	logic              op_ready;
	aes_ret_s          op_ret;
	logic [7:0]        acc;
	logic [3:0]        awaddr = '0, araddr = '0, wstrb = '0;
	logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0]       wdata = '0, rdata;
	logic              awready, wready, bvalid, arready, rvalid;
	logic [1:0]        bresp, rresp;
	int                n_fail = 0, samples_checked = 0;
	logic [31:0]       cnt, rd;
	logic [1:0]        rs;
	aes_ret_s          ret;

	always #4 CLK = ~CLK;

	aes_exec_unit u_dut (.CLK(CLK), .RST(RST), .OP_VALID(op_valid), .OP_REQ(op_req),
		.OP_READY(op_ready), .OP_RET(op_ret), .ACC(acc), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

	aes_dec_model u_dec (.clk(CLK), .op_ready(op_ready), .op_ret(op_ret),
		.op_valid(op_valid), .op_req(op_req));

	// verdict and end of run, reached from the main flow and from lost waits
	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// a wait that used up its bound counts as a mismatch
	task automatic wait_lost;
		n_fail++;
		$display("unexpected at %0t: wait bound %h expected %h", $time, 0, 1);
		test_done();
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// write: address and data offered together, each released once taken
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] resp);
		int i;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge CLK);
			if (awvalid && awready) begin
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
			end
			if (bvalid) begin
				break;
			end
		end
		resp = bresp;
		bready <= 1'b0;
		// let an edge pass so a following write never raises bready in this step
		@(posedge CLK);
		if (i == 40) begin
			wait_lost();
		end
	endtask

	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
		int i;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge CLK);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
			end
			if (rvalid) begin
				break;
			end
		end
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
		// let an edge pass so a following read never raises rready in this step
		@(posedge CLK);
		if (i == 40) begin
			wait_lost();
		end
	endtask

	// read a register and compare value and answer code
	task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
		axi_rd(a, rd, rs);
		chk(rd, exp);
		chk({30'h0, rs}, {30'h0, RESP_OKAY});
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		axi_wr(a, d, rs);
	endtask

	task automatic run(input aes_op_e op, input logic [7:0] lit, input logic [6:0] fa,
		input logic [2:0] bi, input logic dst, input int gap);
		logic ok;
		u_dec.issue('{op: op, lit: lit, faddr: fa, bidx: bi, dest: dst}, gap, ret, ok);
		if (!ok) begin
			wait_lost();
		end
	endtask

	// file byte seen through and-file with an all-ones accumulator
	task automatic peek(input logic [6:0] fa, input logic [7:0] exp);
		wr(ACC_OFS, 32'h0000_00ff);
		run(and_file_op, 8'h00, fa, 3'h0, 1'b0, 0);
		rchk(ACC_OFS, {24'h0, exp});
		chk({24'h0, acc}, {24'h0, exp});
	endtask

	// accumulator, literal, sum, flags {Z, DC, C}
	logic [7:0] add_tab [4][4] = '{'{8'h12, 8'h34, 8'h46, 8'h00}, '{8'h8f, 8'h71, 8'h00, 8'h07},
		'{8'h0f, 8'h01, 8'h10, 8'h02}, '{8'hf0, 8'h20, 8'h10, 8'h01}};

	initial begin
		repeat (6) @(posedge CLK);
		RST <= 1'b0;
		@(posedge CLK);
		rchk(ACC_OFS, 32'h0);
		rchk(FLAG_OFS, 32'h0);
		rchk(CTRL_OFS, 32'h1);
		rchk(COUNT_OFS, 32'h0);
		// additions over carry, nibble carry and zero corners, decoder fast and slow
		for (int i = 0; i < 4; i++) begin
			wr(ACC_OFS, {24'h0, add_tab[i][0]});
			wr(FLAG_OFS, 32'h0);
			run(add_literal_op, add_tab[i][1], 7'h00, 3'h0, 1'b0, i);
			rchk(ACC_OFS, {24'h0, add_tab[i][2]});
			rchk(FLAG_OFS, {24'h0, add_tab[i][3]});
		end
		// and-literal leaves carry and nibble carry as they were
		wr(ACC_OFS, 32'h3c);
		wr(FLAG_OFS, 32'h3);
		run(and_literal_op, 8'hc3, 7'h00, 3'h0, 1'b0, 0);
		rchk(ACC_OFS, 32'h0);
		rchk(FLAG_OFS, 32'h7);
		// every bit index set, then the even ones cleared, at the top file address, flags untouched
		wr(FLAG_OFS, 32'h5);
		for (int b = 0; b < 8; b++) begin
			run(bit_set_op, 8'h00, 7'h7f, b[2:0], 1'b0, 0);
		end
		rchk(FLAG_OFS, 32'h5);
		peek(7'h7f, 8'hff);
		wr(FLAG_OFS, 32'h2);
		for (int b = 0; b < 8; b += 2) begin
			run(bit_clear_op, 8'h00, 7'h7f, b[2:0], 1'b0, 0);
		end
		rchk(FLAG_OFS, 32'h2);
		peek(7'h7f, 8'haa);
		// add-file to each destination
		wr(ACC_OFS, 32'h56);
		wr(FLAG_OFS, 32'h0);
		run(add_file_op, 8'h00, 7'h7f, 3'h0, 1'b0, 0);
		rchk(ACC_OFS, 32'h0);
		rchk(FLAG_OFS, 32'h7);
		wr(ACC_OFS, 32'h11);
		run(add_file_op, 8'h00, 7'h7f, 3'h0, 1'b1, 0);
		rchk(ACC_OFS, 32'h11);
		rchk(FLAG_OFS, 32'h0);
		peek(7'h7f, 8'hbb);
		// and-file back into the file register
		wr(ACC_OFS, 32'h0f);
		wr(FLAG_OFS, 32'h3);
		run(and_file_op, 8'h00, 7'h7f, 3'h0, 1'b1, 0);
		rchk(ACC_OFS, 32'h0f);
		rchk(FLAG_OFS, 32'h3);
		peek(7'h7f, 8'h0b);
		// both tests, hit and miss, on a file byte of 0x0b
		for (int k = 0; k < 4; k++) begin
			wr(ACC_OFS, 32'h1);
			wr(FLAG_OFS, 32'h0);
			axi_rd(COUNT_OFS, cnt, rs);
			run(k < 2 ? skip_if_bit_set_op : skip_if_bit_low_op, 8'h00, 7'h7f,
				k[0] ? 3'h2 : 3'h0, 1'b0, 0);
			chk({31'h0, ret.skip_taken}, {31'h0, k[0] == k[1]});
			run(add_literal_op, 8'h01, 7'h00, 3'h0, 1'b0, 0);
			chk({31'h0, ret.discarded}, {31'h0, k[0] == k[1]});
			rchk(ACC_OFS, (k[0] == k[1]) ? 32'h1 : 32'h2);
			rchk(FLAG_OFS, 32'h0);
			rchk(COUNT_OFS, cnt + 32'd2);
		end
		// an opcode outside the eight retires and changes nothing
		run(nop_op, 8'hff, 7'h7f, 3'h0, 1'b1, 0);
		rchk(ACC_OFS, 32'h1);
		rchk(FLAG_OFS, 32'h0);
		peek(7'h7f, 8'h0b);
		// retired count is read only, disable holds the decoder off
		axi_rd(COUNT_OFS, cnt, rs);
		axi_wr(COUNT_OFS, 32'h0, rs);
		chk({30'h0, rs}, {30'h0, RESP_OKAY});
		rchk(COUNT_OFS, cnt);
		wr(CTRL_OFS, 32'h0);
		@(posedge CLK);
		#1;
		chk({31'h0, op_ready}, 32'h0);
		@(posedge CLK);
		wr(CTRL_OFS, 32'h1);
		rchk(CTRL_OFS, 32'h1);
		test_done();
	end
endmodule
